// File: common/irp_pkg.sv
package irp_pkg;

   // Register pointer values: port 0 even, port 1 odd
   localparam logic [2:0] REG_IN0 = 3'h0;
   localparam logic [2:0] REG_IN1 = 3'h1;
   localparam logic [2:0] REG_OUT0 = 3'h2;
   localparam logic [2:0] REG_OUT1 = 3'h3;
   localparam logic [2:0] REG_POL0 = 3'h4;
   localparam logic [2:0] REG_POL1 = 3'h5;
   localparam logic [2:0] REG_CFG0 = 3'h6;
   localparam logic [2:0] REG_CFG1 = 3'h7;

   // Reset values of the writable pairs
   localparam logic [7:0] RST_OUT = 8'hff;
   localparam logic [7:0] RST_POL = 8'h00;
   localparam logic [7:0] RST_CFG = 8'hff;

   // Write queue shape: 3-bit register index above 8-bit data
   localparam int FIFO_WIDTH = 11;
   localparam int FIFO_DEPTH = 8;

   // Arbitrary 7-bit target address, not a real part's
   localparam logic [6:0] DEV_ADDR = 7'h2a;

   typedef enum logic [2:0] {
      LNK_IDLE,
      LNK_ADDR,
      LNK_ADDR_ACK,
      LNK_CMD,
      LNK_CMD_ACK,
      LNK_TX,
      LNK_TX_ACK
   } irp_link_state_t;

   // Byte of the frozen register image selected by a pointer
   function automatic logic [7:0] irp_byte(input logic [63:0] img, input logic [2:0] idx);
      irp_byte = img[{idx, 3'h0} +: 8];
   endfunction

endpackage

// File: rtl/irp_reader.sv
`timescale 1ns/10ps
`default_nettype none

module irp_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 8
) (
   input wire logic clock,               // System clock
   input wire logic rst_n,               // Synchronised reset, active low
   input wire logic in_valid,            // Write side offers a word
   output logic in_ready,                // Room for a word
   input wire logic [WIDTH-1:0] in_data, // Word written
   output logic out_valid,               // A word is held
   input wire logic out_ready,           // Drain side takes the word
   output logic [WIDTH-1:0] out_data     // Oldest word
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic push, pop;

   assign in_ready = (cnt_reg != DEPTH[AW:0]);
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem_reg[rd_ptr_reg];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      wr_ptr_next = push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
      rd_ptr_next = pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
      cnt_next = cnt_reg;
      if (push && !pop) begin
         cnt_next = (AW+1)'(cnt_reg + 1'b1);
      end else if (pop && !push) begin
         cnt_next = (AW+1)'(cnt_reg - 1'b1);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         cnt_reg <= cnt_next;
      end
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   AST_FIFO_FULL_STALL: assert property (@(posedge clock) disable iff (!rst_n)
      (cnt_reg == DEPTH[AW:0]) |-> !in_ready ##1 $stable(wr_ptr_reg))
      else $error("fifo accepted a word while full");

endmodule

// Functional notes
// R1: The master opens with a start, the address with read/write low, then a command byte.
// R2: The command byte after the address is loaded into the register pointer.
// R3: After a start or restart the master sends the address again with read/write high.
// R4: A read-addressed transfer sends the register under the pointer as its first byte.
// R5: The byte to send is captured on the rising clock edge of the acknowledge bit.
// R6: Each further byte of a read comes from the other register of the pair.
// R7: The master may read any number of bytes and answers the last one with a not-acknowledge.
// R8: The pointer keeps the partner register across a later start or restart.
// R9: Reset release sets all registers and the bus state machine to defaults.
// R10: Eight registers form four pairs: input, output, polarity inversion, direction.
// R11: Registers sit at pointer values 0 to 7, port 0 even and port 1 odd, input port 0 first.
// R12: After each sent byte pointer bit 0 flips and the upper bits stay.
module irp_reader
   import irp_pkg::*;
(
   input wire logic clock,               // System clock, 250 MHz
   input wire logic resetn,              // Reset, active low, asynchronous
   input wire logic scl_clk,             // Serial bus clock from the master
   input wire logic sda_in,              // Serial data line level
   output logic sda_out,                 // Serial data drive level, always low
   output logic sda_oe,                  // Serial data pulled low while high
   input wire logic [15:0] port_in,      // Port pin levels
   output logic [15:0] port_out,         // Output port registers
   output logic [15:0] port_dir_in,      // Direction registers, 1 = input
   input wire logic wr_valid,            // Register write offered
   output logic wr_ready,                // Register write queue has room
   input wire logic [2:0] wr_sel,        // Register index to write
   input wire logic [7:0] wr_data        // Register value to write
);

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_s1_reg, rst_n;

   // R9: reset release
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_s1_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n <= rst_s1_reg;
      end
   end

   // ----------------------------------------
   // Write queue and register file
   // ----------------------------------------
   logic q_valid, q_ready;
   logic [FIFO_WIDTH-1:0] q_data;
   logic [7:2][7:0] regs_reg, regs_next;
   logic [15:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg, pin_next;
   logic bsy_s1_reg, bsy_s2_reg, bsy_s3_reg, busy_reg, busy_next;
   logic [63:0] snap_reg, snap_next;
   logic link_busy, freeze;

   irp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data({wr_sel, wr_data}),
      .out_valid(q_valid),
      .out_ready(q_ready),
      .out_data(q_data)
   );

   // Image must hold still while the link may sample it
   assign freeze = bsy_s2_reg | bsy_s3_reg | busy_reg;
   assign q_ready = ~freeze;

   always_comb begin
      regs_next = regs_reg;
      // R11: index decode
      if (q_valid && q_ready && q_data[10:8] >= REG_OUT0) begin
         regs_next[q_data[10:8]] = q_data[7:0];
      end
      // A pin change counts once the second and third stage agree
      pin_next = (~(pin_s2_reg ^ pin_s3_reg) & pin_s3_reg) | ((pin_s2_reg ^ pin_s3_reg) & pin_reg);
      busy_next = (bsy_s2_reg == bsy_s3_reg) ? bsy_s3_reg : busy_reg;
      // R10: pair image, inputs shown through polarity inversion
      snap_next = freeze ? snap_reg : {regs_reg, pin_reg ^ {regs_reg[REG_POL1], regs_reg[REG_POL0]}};
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         // R9: register defaults
         regs_reg <= {RST_CFG, RST_CFG, RST_POL, RST_POL, RST_OUT, RST_OUT};
         pin_s1_reg <= 16'h0000;
         pin_s2_reg <= 16'h0000;
         pin_s3_reg <= 16'h0000;
         pin_reg <= 16'h0000;
         bsy_s1_reg <= 1'b0;
         bsy_s2_reg <= 1'b0;
         bsy_s3_reg <= 1'b0;
         busy_reg <= 1'b0;
         snap_reg <= 64'h0000000000000000;
      end else begin
         regs_reg <= regs_next;
         pin_s1_reg <= port_in;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         pin_reg <= pin_next;
         bsy_s1_reg <= link_busy;
         bsy_s2_reg <= bsy_s1_reg;
         bsy_s3_reg <= bsy_s2_reg;
         busy_reg <= busy_next;
         snap_reg <= snap_next;
      end
   end

   assign port_out = {regs_reg[REG_OUT1], regs_reg[REG_OUT0]};
   assign port_dir_in = {regs_reg[REG_CFG1], regs_reg[REG_CFG0]};

   // R9: defaults right after release
   AST_REGS_DEFAULT: assert property (@(posedge clock) disable iff (!resetn) // R9
      $rose(rst_n) |-> port_out == {RST_OUT, RST_OUT} && port_dir_in == {RST_CFG, RST_CFG}
         && regs_reg[REG_POL0] == RST_POL && regs_reg[REG_POL1] == RST_POL)
      else $error("registers not at defaults after reset");

   // R10: image frozen while the link is busy
   AST_IMAGE_FROZEN: assert property (@(posedge clock) disable iff (!rst_n) // R10
      busy_reg |=> $stable(snap_reg) && $stable(regs_reg))
      else $error("register image changed during a transfer");

   // ----------------------------------------
   // Start detection on the data line
   // ----------------------------------------
   logic start_tog_reg, start_tog_next;

   assign start_tog_next = scl_clk ? ~start_tog_reg : start_tog_reg;

   always_ff @(negedge sda_in or negedge rst_n) begin
      if (!rst_n) begin
         start_tog_reg <= 1'b0;
      end else begin
         start_tog_reg <= start_tog_next;
      end
   end

   // ----------------------------------------
   // Link state machine, on the bus clock
   // ----------------------------------------
   irp_link_state_t state_reg, state_next;
   logic [2:0] bit_cnt_reg, bit_cnt_next, ptr_reg, ptr_next;
   logic [7:0] rx_reg, rx_next, tx_reg, tx_next, rx_shift;
   logic rw_reg, rw_next, start_seen_reg, start_new;
   logic oe_reg, oe_next;

   assign start_new = start_tog_reg != start_seen_reg;
   assign rx_shift = {rx_reg[6:0], sda_in};
   assign link_busy = (state_reg != LNK_IDLE);

   always_comb begin
      state_next = state_reg;
      bit_cnt_next = 3'(bit_cnt_reg + 3'h1);
      ptr_next = ptr_reg;
      rx_next = rx_reg;
      tx_next = tx_reg;
      rw_next = rw_reg;
      if (start_new) begin
         // R1: first address bit follows the start
         state_next = LNK_ADDR;
         rx_next = {7'h00, sda_in};
         bit_cnt_next = 3'h1;
      end else begin
         unique case (state_reg)
            LNK_IDLE: begin
               bit_cnt_next = 3'h0;
            end
            LNK_ADDR: begin
               rx_next = rx_shift;
               if (bit_cnt_reg == 3'h7) begin
                  // R3: read/write bit decides the direction
                  rw_next = sda_in;
                  state_next = (rx_reg[6:0] == DEV_ADDR) ? LNK_ADDR_ACK : LNK_IDLE;
               end
            end
            LNK_ADDR_ACK: begin
               bit_cnt_next = 3'h0;
               if (rw_reg) begin
                  // R4: first byte from the pointer
                  // R5: capture on the acknowledge rising edge
                  tx_next = irp_byte(snap_reg, ptr_reg);
                  state_next = LNK_TX;
               end else begin
                  state_next = LNK_CMD;
               end
            end
            LNK_CMD: begin
               rx_next = rx_shift;
               if (bit_cnt_reg == 3'h7) begin
                  // R2: command byte loads the pointer
                  ptr_next = rx_shift[2:0];
                  state_next = LNK_CMD_ACK;
               end
            end
            LNK_CMD_ACK: begin
               state_next = LNK_IDLE;
            end
            LNK_TX: begin
               tx_next = {tx_reg[6:0], 1'b0};
               if (bit_cnt_reg == 3'h7) begin
                  // R12: flip to the partner register
                  ptr_next = {ptr_reg[2:1], ~ptr_reg[0]};
                  state_next = LNK_TX_ACK;
               end
            end
            LNK_TX_ACK: begin
               bit_cnt_next = 3'h0;
               // R7: not-acknowledge ends the read
               if (!sda_in) begin
                  // R6: next byte from the other register
                  tx_next = irp_byte(snap_reg, ptr_reg);
                  state_next = LNK_TX;
               end else begin
                  state_next = LNK_IDLE;
               end
            end
         endcase
      end
      oe_next = (state_reg == LNK_ADDR_ACK) || (state_reg == LNK_CMD_ACK)
         || (state_reg == LNK_TX && !tx_reg[7]);
   end

   // R8: pointer survives starts
   always_ff @(posedge scl_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= LNK_IDLE;
         bit_cnt_reg <= 3'h0;
         ptr_reg <= REG_IN0;
         rx_reg <= 8'h00;
         tx_reg <= 8'h00;
         rw_reg <= 1'b0;
         start_seen_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         ptr_reg <= ptr_next;
         rx_reg <= rx_next;
         tx_reg <= tx_next;
         rw_reg <= rw_next;
         start_seen_reg <= start_tog_reg;
      end
   end

   always_ff @(negedge scl_clk or negedge rst_n) begin
      if (!rst_n) begin
         oe_reg <= 1'b0;
      end else begin
         oe_reg <= oe_next;
      end
   end

   assign sda_oe = oe_reg;
   assign sda_out = 1'b0;

   // ----------------------------------------
   // Link checks
   // ----------------------------------------
   sequence s_byte_acked;
      state_reg == LNK_TX_ACK && !sda_in && !start_new;
   endsequence

   sequence s_next_loaded;
      state_reg == LNK_TX && tx_reg == $past(irp_byte(snap_reg, ptr_reg)) && bit_cnt_reg == 3'h0;
   endsequence

   AST_PTR_LOAD: assert property (@(posedge scl_clk) disable iff (!rst_n) // R2
      (state_reg == LNK_CMD && bit_cnt_reg == 3'h7 && !start_new) |=> ptr_reg == $past(rx_shift[2:0]))
      else $error("command byte not loaded into pointer");

   AST_FIRST_BYTE: assert property (@(posedge scl_clk) disable iff (!rst_n) // R4
      (state_reg == LNK_ADDR_ACK && rw_reg && !start_new) |=> s_next_loaded)
      else $error("first read byte not from pointed register");

   AST_ACK_CAPTURE: assert property (@(posedge scl_clk) disable iff (!rst_n) // R5
      s_byte_acked |=> s_next_loaded)
      else $error("byte not captured at acknowledge edge");

   AST_PAIR_FLIP: assert property (@(posedge scl_clk) disable iff (!rst_n) // R12
      (state_reg == LNK_TX && bit_cnt_reg == 3'h7 && !start_new)
         |=> ptr_reg == {$past(ptr_reg[2:1]), ~$past(ptr_reg[0])} && state_reg == LNK_TX_ACK)
      else $error("pointer did not move to partner register");

   AST_ALTERNATE: assert property (@(posedge scl_clk) disable iff (!rst_n) // R6
      (state_reg == LNK_TX && bit_cnt_reg == 3'h0 && !start_new) ##7 (!start_new) ##1 s_byte_acked
         |=> tx_reg == irp_byte(snap_reg, {$past(ptr_reg[2:1], 9), ~$past(ptr_reg[0], 9)}))
      else $error("consecutive bytes did not alternate in the pair");

   AST_PTR_KEEP: assert property (@(posedge scl_clk) disable iff (!rst_n) // R8
      start_new |=> $stable(ptr_reg) && state_reg == LNK_ADDR)
      else $error("pointer changed by a start");

   AST_NACK_END: assert property (@(posedge scl_clk) disable iff (!rst_n) // R7
      (state_reg == LNK_TX_ACK && sda_in && !start_new) |=> state_reg == LNK_IDLE)
      else $error("read continued after not-acknowledge");

   AST_ACK_DRIVE: assert property (@(negedge scl_clk) disable iff (!rst_n) // R2
      (state_reg == LNK_CMD_ACK) |=> sda_oe)
      else $error("command byte not acknowledged");

endmodule

`default_nettype wire

// File: sim/irp_i2c_master.sv
`timescale 1ns/10ps
`default_nettype none

module irp_i2c_master (
   output logic scl,    // Serial clock, toggles only within frames
   output logic sda_oe, // High while the master pulls data low
   input wire logic sda // Resolved data line, pulled up
);
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end

   task automatic put_bit(input logic b);
      #16 sda_oe = ~b;
      #16 scl = 1'b1;
      #32 scl = 1'b0;
   endtask

   task automatic get_bit(output logic b);
      #16 sda_oe = 1'b0;
      #16 scl = 1'b1;
      #16 b = sda;
      #16 scl = 1'b0;
   endtask

   task automatic send_byte(input logic [7:0] v, output logic ack);
      for (int i = 7; i >= 0; i--) put_bit(v[i]);
      get_bit(ack);
   endtask

   task automatic recv_byte(input logic last, output logic [7:0] v);
      for (int i = 7; i >= 0; i--) get_bit(v[i]);
      put_bit(last);
   endtask

   // Data falls while the clock is high; offset keeps it off the system clock edges only when called on one
   task automatic start();
      #17 sda_oe = 1'b0;
      #16 scl = 1'b1;
      #32 sda_oe = 1'b1;
      #32 scl = 1'b0;
   endtask

   task automatic stop();
      #16 sda_oe = 1'b1;
      #16 scl = 1'b1;
      #32 sda_oe = 1'b0;
   endtask
endmodule

`default_nettype wire

// File: sim/irp_reader_tb.sv
`timescale 1ns/10ps
`default_nettype none

module irp_reader_tb;
   import irp_pkg::*;

   logic clock, resetn, scl, m_oe, sda_oe, sda_out, wr_valid, wr_ready;
   logic [15:0] port_in, port_out, port_dir_in;
   logic [2:0] wr_sel, ptr_exp;
   logic [7:0] wr_data;
   logic [7:0] exp_reg [0:7];
   wire sda_line = ((sda_oe & ~sda_out) | m_oe) ? 1'b0 : 1'b1;
   int error_cnt = 0;
   int n_compared = 0;
   int cyc = 0;

   irp_reader i_irp_reader (.clock(clock), .resetn(resetn), .scl_clk(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .port_in(port_in), .port_out(port_out),
      .port_dir_in(port_dir_in), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_sel(wr_sel),
      .wr_data(wr_data));
   irp_i2c_master i_irp_i2c_master (.scl(scl), .sda_oe(m_oe), .sda(sda_line));

   always #2 clock = ~clock;

   task automatic close_out();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         close_out();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] exp_of(input logic [2:0] p);
      if (p < 3'h2) return port_in[8*p[0] +: 8] ^ exp_reg[{2'b10, p[0]}];
      return exp_reg[p];
   endfunction

   function automatic void reset_exp();
      exp_reg[2] = RST_OUT;
      exp_reg[3] = RST_OUT;
      exp_reg[4] = RST_POL;
      exp_reg[5] = RST_POL;
      exp_reg[6] = RST_CFG;
      exp_reg[7] = RST_CFG;
   endfunction

   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      @(negedge clock);
      wr_valid = 1'b1;
      wr_sel = s;
      wr_data = d;
      // Ready is judged where it has settled, then the next rising edge takes the word
      while (wr_ready !== 1'b1) @(negedge clock);
      @(posedge clock);
      @(negedge clock);
      wr_valid = 1'b0;
   endtask

   task automatic do_reset();
      @(negedge clock);
      resetn = 1'b0;
      repeat (6) @(negedge clock);
      resetn = 1'b1;
      reset_exp();
      ptr_exp = REG_IN0;
      repeat (4) @(negedge clock);
      chk(port_out, 16'hffff);
      chk(port_dir_in, 16'hffff);
   endtask

   task automatic bus_read(input logic use_cmd, input logic [2:0] p, input int n);
      logic a;
      logic [7:0] d;
      logic [2:0] q;
      q = use_cmd ? p : ptr_exp;
      i_irp_i2c_master.start();
      if (use_cmd) begin
         i_irp_i2c_master.send_byte({DEV_ADDR, 1'b0}, a);
         chk({15'h0000, a}, 16'h0000);
         i_irp_i2c_master.send_byte({5'($urandom), p}, a);
         chk({15'h0000, a}, 16'h0000);
         i_irp_i2c_master.start();
      end
      i_irp_i2c_master.send_byte({DEV_ADDR, 1'b1}, a);
      chk({15'h0000, a}, 16'h0000);
      for (int i = 0; i < n; i++) begin
         i_irp_i2c_master.recv_byte(i == n - 1, d);
         chk({8'h00, d}, {8'h00, exp_of(q)});
         q = q ^ 3'h1;
      end
      ptr_exp = q;
      i_irp_i2c_master.stop();
   endtask

   initial begin
      logic a;
      logic [2:0] s;
      logic [7:0] d;
      clock = 1'b0;
      resetn = 1'b0;
      port_in = 16'h0000;
      wr_valid = 1'b0;
      wr_sel = 3'h0;
      wr_data = 8'h00;
      ptr_exp = 3'h0;
      void'($urandom(32'h9771));
      do_reset();
      for (int k = 0; k < 8; k++) begin
         @(negedge clock);
         port_in = 16'($urandom);
         for (int j = 0; j < 5; j++) begin
            s = 3'($urandom);
            d = 8'($urandom);
            wr(s, d);
            if (s > 3'h1) exp_reg[s] = d;
         end
         repeat (40) @(negedge clock);
         chk(port_out, {exp_reg[3], exp_reg[2]});
         chk(port_dir_in, {exp_reg[7], exp_reg[6]});
         bus_read(1'b1, 3'(k), 1 + $urandom_range(3));
         bus_read(1'b0, 3'h0, 2);
      end
      // Foreign address is ignored and the pointer survives it
      i_irp_i2c_master.start();
      i_irp_i2c_master.send_byte({DEV_ADDR ^ 7'h01, 1'b1}, a);
      chk({15'h0000, a}, 16'h0001);
      i_irp_i2c_master.stop();
      bus_read(1'b0, 3'h0, 3);
      // Queue fills while a transfer stalls its drain
      fork
         bus_read(1'b1, 3'h3, 2);
         begin
            repeat (100) @(negedge clock);
            for (int j = 0; j < 8; j++) begin
               d = 8'($urandom);
               wr(3'(2 + j % 6), d);
               // Drained in the command gap, before the read image freezes
               exp_reg[2 + j % 6] = d;
            end
            chk({15'h0000, wr_ready}, 16'h0000);
         end
      join
      repeat (60) @(negedge clock);
      chk(port_out, {exp_reg[3], exp_reg[2]});
      chk(port_dir_in, {exp_reg[7], exp_reg[6]});
      do_reset();
      bus_read(1'b0, 3'h0, 2);
      for (int k = 2; k < 8; k += 2) bus_read(1'b1, 3'(k + 1), 2);
      close_out();
   end
endmodule

`default_nettype wire
